/* File: hdl/mpo_pkg.sv */
// Register map, reset values and carrier types of the general pin port
package mpo_pkg;
  localparam int          MPO_PINS      = 16;
  localparam int          MPO_SET_W     = 8;
  localparam logic [7:0]  MPO_SET1_BASE = 8'h20;
  localparam logic [4:0]  MPO_OFS_IRQEN = 5'h00;
  localparam logic [4:0]  MPO_OFS_LEVEL = 5'h04;
  localparam logic [4:0]  MPO_OFS_TRI   = 5'h08;
  localparam logic [4:0]  MPO_OFS_INV   = 5'h0c;
  localparam logic [4:0]  MPO_OFS_DIR   = 5'h10;
  localparam logic [4:0]  MPO_OFS_OD    = 5'h14;
  localparam logic [7:0]  MPO_ADR_STAT  = 8'h40;
  localparam logic [7:0]  MPO_ADR_MASK  = 8'h44;
  localparam logic [7:0]  MPO_ADR_CTRL  = 8'h48;
  localparam int          MPO_CTRL_TMR  = 0;
  localparam int          MPO_STAT_PIN  = 0;
  localparam logic [7:0]  MPO_RST_DIR   = 8'hff;
  localparam logic [7:0]  MPO_RST_ZERO  = 8'h00;
  localparam logic [1:0]  MPO_RESP_OK   = 2'h0;
  localparam logic [1:0]  MPO_RESP_ERR  = 2'h2;
  localparam int          MPO_SYNC_LEN  = 2;

  typedef enum logic [3:0] {
    MPO_K_NONE, MPO_K_IRQEN, MPO_K_LEVEL, MPO_K_TRI, MPO_K_INV,
    MPO_K_DIR, MPO_K_OD, MPO_K_STAT, MPO_K_MASK, MPO_K_CTRL
  } mpo_kind_t;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } mpo_drive_t;

  typedef struct packed {
    mpo_kind_t kind;
    logic      hi;
  } mpo_sel_t;
endpackage

/* File: hdl/mpo_port.sv */
// General pin port: sixteen configurable pins behind an AXI4-Lite slave
`timescale 1ns/100ps
module mpo_port import mpo_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int PINS   = MPO_PINS
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  // Pins and timer
  input  wire logic [PINS-1:0]   i_pin_in,
  output logic [PINS-1:0]        o_pin_out,
  output logic [PINS-1:0]        o_pin_oe,
  input  wire logic              i_timer_out,
  // Interrupts
  output logic                   o_pin_irq,
  output logic                   o_irq
);
  if (PINS != 2 * MPO_SET_W || ADDR_W < 8) begin : g_bad_cfg
    $error("mpo_port: PINS must be 16 and ADDR_W at least 8");
  end

  function automatic mpo_sel_t decode(input logic [ADDR_W-1:0] a);
    mpo_sel_t s;
    s.kind = MPO_K_NONE;
    s.hi   = a[5];
    if (a[ADDR_W-1:7] == '0 && a[1:0] == 2'h0) begin
      if (a[6] == 1'b0) begin
        case (a[4:0])
          MPO_OFS_IRQEN: s.kind = MPO_K_IRQEN;
          MPO_OFS_LEVEL: s.kind = MPO_K_LEVEL;
          MPO_OFS_TRI:   s.kind = MPO_K_TRI;
          MPO_OFS_INV:   s.kind = MPO_K_INV;
          MPO_OFS_DIR:   s.kind = MPO_K_DIR;
          MPO_OFS_OD:    s.kind = MPO_K_OD;
          default:       s.kind = MPO_K_NONE;
        endcase
      end else begin
        case (a[7:0])
          MPO_ADR_STAT: s.kind = MPO_K_STAT;
          MPO_ADR_MASK: s.kind = MPO_K_MASK;
          MPO_ADR_CTRL: s.kind = MPO_K_CTRL;
          default:      s.kind = MPO_K_NONE;
        endcase
      end
    end
    return s;
  endfunction

  // Byte lane 0 updates the half that the address picks
  function automatic logic [15:0] upd(input logic [15:0] cur, input logic hi,
                                      input logic [7:0] d);
    return hi ? {d, cur[7:0]} : {cur[15:8], d};
  endfunction

  function automatic logic [7:0] half(input logic [15:0] v, input logic hi);
    return hi ? v[15:8] : v[7:0];
  endfunction

  // Pin registers, one 16-bit vector per kind, two byte-wide sets
  logic [15:0] pin_irq_enable;
  logic [15:0] pin_level;
  logic [15:0] pin_tristate;
  logic [15:0] pin_input_invert;
  logic [15:0] pin_direction;
  logic [15:0] pin_open_drain;
  logic        timer_sel;
  logic        irq_status;
  logic        irq_mask;

  // Write channel holding
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic              w_lane0;
  logic              do_write;
  logic              next_aw_held;
  logic              next_w_held;
  logic              next_bvalid;
  mpo_sel_t          wsel;

  assign do_write     = aw_held && w_held && !o_bvalid;
  assign next_aw_held = (aw_held && !do_write) || (i_awvalid && o_awready);
  assign next_w_held  = (w_held && !do_write) || (i_wvalid && o_wready);
  assign next_bvalid  = do_write || (o_bvalid && !i_bready);
  assign wsel         = decode(aw_addr);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr   <= '0;
      w_data    <= '0;
      w_lane0   <= 1'b0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= MPO_RESP_OK;
    end else begin
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      o_awready <= !next_aw_held && !next_bvalid;
      o_wready  <= !next_w_held && !next_bvalid;
      o_bvalid  <= next_bvalid;
      if (i_awvalid && o_awready) begin
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_data  <= i_wdata;
        w_lane0 <= i_wstrb[0];
      end
      if (do_write) begin
        o_bresp <= (wsel.kind == MPO_K_NONE) ? MPO_RESP_ERR : MPO_RESP_OK;
      end
    end
  end

  logic wr_en;
  assign wr_en = do_write && w_lane0;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pin_irq_enable   <= {2{MPO_RST_ZERO}};
      pin_level        <= {2{MPO_RST_ZERO}};
      pin_tristate     <= {2{MPO_RST_ZERO}};
      pin_input_invert <= {2{MPO_RST_ZERO}};
      pin_direction    <= {2{MPO_RST_DIR}};
      pin_open_drain   <= {2{MPO_RST_ZERO}};
      timer_sel        <= 1'b0;
      irq_mask         <= 1'b0;
    end else if (wr_en) begin
      case (wsel.kind)
        MPO_K_IRQEN: pin_irq_enable   <= upd(pin_irq_enable, wsel.hi, w_data[7:0]);
        MPO_K_LEVEL: pin_level        <= upd(pin_level, wsel.hi, w_data[7:0]);
        MPO_K_TRI:   pin_tristate     <= upd(pin_tristate, wsel.hi, w_data[7:0]);
        MPO_K_INV:   pin_input_invert <= upd(pin_input_invert, wsel.hi, w_data[7:0]);
        MPO_K_DIR:   pin_direction    <= upd(pin_direction, wsel.hi, w_data[7:0]);
        MPO_K_OD:    pin_open_drain   <= upd(pin_open_drain, wsel.hi, w_data[7:0]);
        MPO_K_MASK:  irq_mask         <= w_data[MPO_STAT_PIN];
        MPO_K_CTRL:  timer_sel        <= w_data[MPO_CTRL_TMR];
        default:     timer_sel        <= timer_sel;
      endcase
    end
  end

  // Input path: only sync_b is read beyond the first stage
  logic [15:0] sync_a;
  logic [15:0] sync_b;
  logic [15:0] level_in;
  logic [15:0] trig;
  logic [15:0] trig_q;
  logic [15:0] cand;
  logic [15:0] edge_hit;
  logic [15:0] pend;
  logic [15:0] level_read;
  logic [15:0] tmr_mask;

  assign tmr_mask   = {15'h0000, timer_sel};
  assign level_in   = sync_b ^ pin_input_invert;
  assign level_read = (pin_direction & level_in) | (~pin_direction & pin_level);
  // Active edge chosen by inversion and level bits together
  assign trig       = level_in ^ pin_level;
  assign cand       = pin_irq_enable & pin_direction & ~tmr_mask;
  assign edge_hit   = trig & ~trig_q & cand;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sync_a <= '0;
      sync_b <= '0;
      trig_q <= '0;
    end else begin
      sync_a <= i_pin_in;
      sync_b <= sync_a;
      trig_q <= trig;
    end
  end

  // Read channel
  mpo_sel_t rsel;
  logic     ar_hs;
  logic     lvl_rd;
  logic     next_rvalid;
  logic     stat_clr;
  assign rsel        = decode(i_araddr);
  assign ar_hs       = i_arvalid && o_arready;
  assign lvl_rd      = ar_hs && rsel.kind == MPO_K_LEVEL;
  assign next_rvalid = ar_hs || (o_rvalid && !i_rready);
  assign stat_clr    = wr_en && wsel.kind == MPO_K_STAT && w_data[MPO_STAT_PIN];

  // New edges win over the read-side clear
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~{16{lvl_rd}}) | edge_hit;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      irq_status <= 1'b0;
      o_pin_irq  <= 1'b0;
      o_irq      <= 1'b0;
    end else begin
      irq_status <= (irq_status && !stat_clr) || (|edge_hit);
      o_pin_irq  <= |pend;
      o_irq      <= irq_status && irq_mask;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= MPO_RESP_OK;
    end else begin
      o_arready <= !next_rvalid;
      o_rvalid  <= next_rvalid;
      if (ar_hs) begin
        o_rresp <= (rsel.kind == MPO_K_NONE) ? MPO_RESP_ERR : MPO_RESP_OK;
        case (rsel.kind)
          MPO_K_IRQEN: o_rdata <= {24'h000000, half(pin_irq_enable, rsel.hi)};
          MPO_K_LEVEL: o_rdata <= {24'h000000, half(level_read, rsel.hi)};
          MPO_K_TRI:   o_rdata <= {24'h000000, half(pin_tristate, rsel.hi)};
          MPO_K_INV:   o_rdata <= {24'h000000, half(pin_input_invert, rsel.hi)};
          MPO_K_DIR:   o_rdata <= {24'h000000, half(pin_direction, rsel.hi)};
          MPO_K_OD:    o_rdata <= {24'h000000, half(pin_open_drain, rsel.hi)};
          MPO_K_STAT:  o_rdata <= {31'h00000000, irq_status};
          MPO_K_MASK:  o_rdata <= {31'h00000000, irq_mask};
          MPO_K_CTRL:  o_rdata <= {31'h00000000, timer_sel};
          default:     o_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Pin drive, registered so the pads see no decode glitches
  mpo_drive_t drv;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      drv.out[i] = pin_level[i];
      drv.oe[i]  = 1'b1;
      if (pin_direction[i] || pin_tristate[i]) begin
        drv.oe[i] = 1'b0;
      end else if (pin_open_drain[i]) begin
        drv.out[i] = 1'b0;
        drv.oe[i]  = !pin_level[i];
      end
    end
    if (timer_sel) begin
      drv.out[0] = i_timer_out;
      drv.oe[0]  = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_pin_out <= '0;
      o_pin_oe  <= '0;
    end else begin
      o_pin_out <= drv.out;
      o_pin_oe  <= drv.oe;
    end
  end

  // Checks
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  logic [15:0] in_mask;
  logic [15:0] pp_mask;
  assign in_mask = pin_direction & ~tmr_mask;
  assign pp_mask = ~pin_direction & ~pin_tristate & ~pin_open_drain & ~tmr_mask;

  chk_input_float: assert property (##1 (o_pin_oe & $past(in_mask)) == 16'h0000)
    else $error("input pin is driven");
  chk_level_drive: assert property (##1 ((o_pin_out ^ $past(pin_level)) & $past(pp_mask)) == 16'h0000)
    else $error("push-pull pin does not follow level");
  chk_tristate_off: assert property (##1 (o_pin_oe & $past(pin_tristate & ~tmr_mask)) == 16'h0000)
    else $error("tri-stated pin is driven");
  chk_od_low_only: assert property (##1 (o_pin_oe & o_pin_out & $past(pin_open_drain & ~tmr_mask)) == 16'h0000)
    else $error("open-drain pin drives high");
  chk_timer_pin: assert property (timer_sel |=> o_pin_oe[0] && o_pin_out[0] == $past(i_timer_out))
    else $error("timer not on pin zero");
  chk_level_clear: assert property (lvl_rd && edge_hit == 16'h0000 |=> pend == 16'h0000 ##1 !o_pin_irq)
    else $error("level read did not clear interrupt");
  chk_edge_raise: assert property (|edge_hit |-> ##[1:2] o_pin_irq)
    else $error("edge did not raise request");
  chk_no_out_irq: assert property (##1 (pend & ~$past(pend) & ~$past(cand)) == 16'h0000)
    else $error("interrupt from disabled or output pin");
  chk_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");

  // Bus handshakes: answers hold and no second request slips in
  chk_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read data dropped");
  chk_wr_closed: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted under response");
  chk_rd_closed: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted under data");
  chk_wr_once: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("write response repeated");
  chk_rd_once: assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("read data repeated");
  chk_bad_wresp: assert property (do_write && wsel.kind == MPO_K_NONE |=> o_bresp == MPO_RESP_ERR)
    else $error("unmapped write answered okay");
  chk_bad_rresp: assert property (ar_hs && rsel.kind == MPO_K_NONE
                                  |=> o_rresp == MPO_RESP_ERR && o_rdata == 32'h00000000)
    else $error("unmapped read answered okay");

  // Register and pin state
  chk_dir_reset: assert property ($rose(i_reset_n) |-> pin_direction == {2{MPO_RST_DIR}})
    else $error("pins not input after reset");
  chk_oe_reset: assert property ($rose(i_reset_n) |-> o_pin_oe == 16'h0000 && !o_pin_irq && !o_irq)
    else $error("outputs active right after reset");
  chk_level_read: assert property (lvl_rd |=> o_rdata[7:0] == half($past(level_read), $past(rsel.hi)))
    else $error("level read returns wrong value");
  chk_od_input: assert property (##1 (o_pin_oe & $past(pin_open_drain & in_mask)) == 16'h0000)
    else $error("open-drain setting drives input pin");

  // Interrupt path
  chk_pin_irq_or: assert property (##1 o_pin_irq == |$past(pend))
    else $error("request is not the OR of pending pins");
  chk_stat_set: assert property (|edge_hit |=> irq_status)
    else $error("edge not recorded in status");
  chk_stat_sticky: assert property (irq_status && !stat_clr |=> irq_status)
    else $error("status bit lost without clear");
  chk_irq_mask: assert property (##1 o_irq == $past(irq_status && irq_mask))
    else $error("interrupt output ignores mask");
  chk_pend_hold: assert property (|pend && !lvl_rd |=> (pend & $past(pend)) == $past(pend))
    else $error("pending pin lost without level read");
  chk_timer_no_irq: assert property (timer_sel |-> !edge_hit[0])
    else $error("timer pin raised interrupt");

  cov_pin_irq: cover property (|edge_hit ##[1:4] lvl_rd);
  cov_timer: cover property (timer_sel && o_pin_oe[0]);
  cov_od_release: cover property (|(pin_open_drain & ~pin_direction & pin_level));
  cov_irq_out: cover property (o_irq);
  cov_bad_addr: cover property (o_bvalid && o_bresp == MPO_RESP_ERR);
endmodule

/* File: verif/mpo_board.sv */
// Board model: pin wiring with pull-ups and external drivers
`timescale 1ns/100ps
module mpo_board (
  // Design side
  input  wire logic [15:0] i_pin_out,
  input  wire logic [15:0] i_pin_oe,
  // Board side
  input  wire logic [15:0] i_drive,
  input  wire logic [15:0] i_drive_en,
  output logic [15:0]      o_level
);
  // Released pins with no board driver float to the pull-up, never to a stale value
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      o_level[i] = i_pin_oe[i] ? i_pin_out[i] : (i_drive_en[i] ? i_drive[i] : 1'b1);
    end
  end
endmodule

/* File: verif/mpo_port_tb.sv */
// Self-checking bench for the general pin port
`timescale 1ns/100ps
module mpo_port_tb import mpo_pkg::*;;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [7:0]  i_awaddr = 8'h00;
  logic [7:0]  i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic        i_arvalid = 1'b0, i_rready = 1'b0, i_timer_out = 1'b0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_pin_irq, o_irq;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [15:0] o_pin_out, o_pin_oe, pin_lvl;
  logic [15:0] drv = 16'h0000;
  logic [15:0] drv_en = 16'hffff;
  logic [33:0] exp_q[$];
  logic [4:0]  ofs[6] = '{MPO_OFS_IRQEN, MPO_OFS_LEVEL, MPO_OFS_TRI, MPO_OFS_INV, MPO_OFS_DIR, MPO_OFS_OD};
  logic [7:0]  rv;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #12.5 i_clk = ~i_clk;

  mpo_port u_mpo_port (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(4'h1), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .i_pin_in(pin_lvl), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .i_timer_out(i_timer_out),
    .o_pin_irq(o_pin_irq), .o_irq(o_irq));

  mpo_board u_mpo_board (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_drive(drv), .i_drive_en(drv_en),
    .o_level(pin_lvl));

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] ra(input logic s, input logic [4:0] o);
    return (s ? MPO_SET1_BASE : 8'h00) | {3'h0, o};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    i_awaddr <= a;
    i_wdata <= {24'h0, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    fork
      begin do @(posedge i_clk); while (!o_awready); i_awvalid <= 1'b0; end
      begin do @(posedge i_clk); while (!o_wready); i_wvalid <= 1'b0; end
    join
    do @(posedge i_clk); while (!o_bvalid);
    check({32'h0, o_bresp}, {32'h0, er});
    i_bready <= 1'b0;
    @(posedge i_clk);
  endtask

  // Expected word is queued; the monitor compares on the data handshake
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    exp_q.push_back({er, 24'h0, d});
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_clk); while (!o_arready);
    i_arvalid <= 1'b0;
    do @(posedge i_clk); while (!o_rvalid);
    i_rready <= 1'b0;
    @(posedge i_clk);
  endtask

  // Only driven bits of the output value are meaningful
  task automatic pins(input logic [15:0] m, input logic [15:0] eo, input logic [15:0] ee);
    check({2'h0, o_pin_out & o_pin_oe & m, o_pin_oe & m}, {2'h0, eo, ee});
  endtask

  task automatic irqs(input logic p, input logic q);
    repeat (6) @(posedge i_clk);
    check({32'h0, o_pin_irq, o_irq}, {32'h0, p, q});
  endtask

  always @(posedge i_clk) begin
    if (o_rvalid && i_rready) begin
      check({o_rresp, o_rdata}, exp_q.pop_front());
    end
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    rv = 8'($urandom(4));
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    for (int k = 0; k < 12; k++) begin
      rd(ra(k / 6, ofs[k % 6]), (k % 6 == 4) ? MPO_RST_DIR : MPO_RST_ZERO, MPO_RESP_OK);
    end
    rd(MPO_ADR_STAT, 8'h00, MPO_RESP_OK);
    rd(8'h3c, 8'h00, MPO_RESP_ERR);
    wr(8'h3c, 8'hff, MPO_RESP_ERR);
    rv = 8'($urandom);
    wr(ra(1, MPO_OFS_INV), rv, MPO_RESP_OK);
    rd(ra(1, MPO_OFS_INV), rv, MPO_RESP_OK);
    wr(ra(1, MPO_OFS_INV), 8'h00, MPO_RESP_OK);
    drv_en <= 16'hff00;
    wr(ra(0, MPO_OFS_DIR), 8'h00, MPO_RESP_OK);
    wr(ra(0, MPO_OFS_LEVEL), 8'ha5, MPO_RESP_OK);
    pins(16'h00ff, 16'h00a5, 16'h00ff);
    rd(ra(0, MPO_OFS_LEVEL), 8'ha5, MPO_RESP_OK);
    wr(ra(0, MPO_OFS_TRI), 8'h0f, MPO_RESP_OK);
    wr(ra(0, MPO_OFS_OD), 8'hf0, MPO_RESP_OK);
    pins(16'h00ff, 16'h0000, 16'h0050);
    wr(ra(1, MPO_OFS_OD), 8'hff, MPO_RESP_OK);
    pins(16'hff00, 16'h0000, 16'h0000);
    wr(MPO_ADR_MASK, 8'h01, MPO_RESP_OK);
    wr(ra(0, MPO_OFS_IRQEN), 8'hff, MPO_RESP_OK);
    wr(ra(1, MPO_OFS_IRQEN), 8'hfd, MPO_RESP_OK);
    wr(ra(0, MPO_OFS_LEVEL), 8'h5a, MPO_RESP_OK);
    irqs(1'b0, 1'b0);
    drv[9] <= 1'b1;
    irqs(1'b0, 1'b0);
    drv[8] <= 1'b1;
    irqs(1'b1, 1'b1);
    rd(ra(1, MPO_OFS_LEVEL), 8'h03, MPO_RESP_OK);
    irqs(1'b0, 1'b1);
    rd(MPO_ADR_STAT, 8'h01, MPO_RESP_OK);
    wr(MPO_ADR_STAT, 8'h01, MPO_RESP_OK);
    irqs(1'b0, 1'b0);
    drv[10] <= 1'b1;
    irqs(1'b1, 1'b1);
    rd(ra(1, MPO_OFS_LEVEL), 8'h07, MPO_RESP_OK);
    wr(MPO_ADR_STAT, 8'h01, MPO_RESP_OK);
    wr(ra(1, MPO_OFS_INV), 8'h04, MPO_RESP_OK);
    irqs(1'b0, 1'b0);
    drv[10] <= 1'b0;
    irqs(1'b1, 1'b1);
    rd(ra(1, MPO_OFS_LEVEL), 8'h07, MPO_RESP_OK);
    wr(MPO_ADR_CTRL, 8'h01, MPO_RESP_OK);
    i_timer_out <= 1'b1;
    repeat (3) @(posedge i_clk);
    pins(16'h0001, 16'h0001, 16'h0001);
    i_timer_out <= 1'b0;
    repeat (3) @(posedge i_clk);
    pins(16'h0001, 16'h0000, 16'h0001);
    test_done();
  end
endmodule
